// >>> cfr_monitor.sv
// Purpose: Port assertions for the fault response block
// Assumes: One clock, async high reset
// Notes:   Pins pass two sync flops, so causes sit 3 edges back
`timescale 1ns/1ps
module cfr_monitor #(
  parameter int unsigned UNIT_CYCLES = 4
) (
  // Clock and reset
  input logic       mclk_i,
  input logic       rst_i,
  // Inputs watched
  input logic       cmd_stb_i,
  input logic       cmd_wr_i,
  input logic       clear_faults_i,
  input logic [1:0] oc_fault_i,
  input logic [1:0] uc_fault_i,
  input logic [1:0] on_cmd_i,
  input logic       bias_ok_i,
  // Outputs watched
  input logic       rd_ack_o,
  input logic [1:0] out_en_o,
  input logic [1:0] oc_flag_o,
  input logic [1:0] uc_flag_o,
  input logic       host_alert_n_o
);
  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  property p_rd_ack;   cmd_stb_i && !cmd_wr_i |=> rd_ack_o; endproperty
  property p_ack_src;  rd_ack_o |-> $past(cmd_stb_i && !cmd_wr_i); endproperty
  property p_oc_flag;  oc_fault_i[0] [*3] |=> oc_flag_o[0]; endproperty
  property p_uc_flag;  uc_fault_i[1] [*3] |=> uc_flag_o[1]; endproperty
  property p_alert;    (|{oc_flag_o, uc_flag_o}) |-> !host_alert_n_o; endproperty
  property p_hold;     oc_flag_o[0] && !clear_faults_i |=> oc_flag_o[0]; endproperty
  property p_clr;      $fell(uc_flag_o[1]) |-> $past(clear_faults_i); endproperty
  property p_en_src;   $rose(out_en_o[0]) |-> $past(on_cmd_i[0] && bias_ok_i, 3); endproperty
  // Alert drop must trace to a pin seen three edges back
  property p_alert_src; $fell(host_alert_n_o) |-> $past(|{oc_fault_i, uc_fault_i}, 3); endproperty
  a_rd_ack:    assert property (p_rd_ack) else $error("read not answered");
  a_ack_src:   assert property (p_ack_src) else $error("stray read answer");
  a_oc_flag:   assert property (p_oc_flag) else $error("oc flag not set");
  a_uc_flag:   assert property (p_uc_flag) else $error("uc flag not set");
  a_alert:     assert property (p_alert) else $error("alert high with flag set");
  a_hold:      assert property (p_hold) else $error("flag lost without clear");
  a_clr:       assert property (p_clr) else $error("flag fell without clear");
  a_en_src:    assert property (p_en_src) else $error("output on while off");
  a_alert_src: assert property (p_alert_src) else $error("alert without fault");
  // Main scenarios reached
  c_read:  cover property (rd_ack_o);
  c_retry: cover property ($rose(out_en_o[0]));
  c_clear: cover property ($fell(uc_flag_o[1]));
endmodule
bind cfr_top cfr_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) u_mon (.mclk_i(mclk_i), .rst_i(rst_i),
  .cmd_stb_i(cmd_stb_i), .cmd_wr_i(cmd_wr_i), .clear_faults_i(clear_faults_i), .oc_fault_i(oc_fault_i),
  .uc_fault_i(uc_fault_i), .on_cmd_i(on_cmd_i), .bias_ok_i(bias_ok_i), .rd_ack_o(rd_ack_o),
  .out_en_o(out_en_o), .oc_flag_o(oc_flag_o), .uc_flag_o(uc_flag_o), .host_alert_n_o(host_alert_n_o));

// >>> cfr_pkg.sv
// Purpose: Shared constants and types for the current fault response block
// Assumes: 50 MHz system clock, two output pages
// Notes:   Command codes are the management bus codes of the two cfg bytes
package cfr_pkg;

  // ----------------------------------------
  // Command codes and reset values
  // ----------------------------------------
  localparam logic [7:0] CMD_OC_CFG = 8'he5;
  localparam logic [7:0] CMD_UC_CFG = 8'he6;
  localparam logic [7:0] RST_OC_CFG = 8'h80;
  localparam logic [7:0] RST_UC_CFG = 8'h80;
  localparam logic [7:0] RD_NONE    = 8'h00;

  // ----------------------------------------
  // Field layout of a cfg byte
  // ----------------------------------------
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DLY_MSB   = 2;
  localparam int DLY_LSB   = 0;

  localparam logic [1:0] RESP_LATCH  = 2'h2;
  localparam logic [1:0] RESP_FOLLOW = 2'h3;
  localparam logic [2:0] RETRY_NONE  = 3'h0;
  localparam logic [2:0] RETRY_LOOP  = 3'h7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ   = 50_000_000;
  localparam int UNIT_MS  = 35;
  localparam int UNIT_CYC = UNIT_MS * (CLK_HZ / 1000);
  localparam int PRE_W    = 21;
  localparam int NPAGE    = 2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_RUN    = 4'b0001,
    ST_HOLD   = 4'b0010,
    ST_FOLLOW = 4'b0100,
    ST_RETRY  = 4'b1000
  } cfr_state_t;

  typedef enum logic [1:0] {
    ACT_HOLD   = 2'h0,
    ACT_RETRY  = 2'h1,
    ACT_FOLLOW = 2'h2
  } cfr_act_t;

  // Reserved codes fall back to latched shutdown
  function automatic cfr_act_t cfr_decode(input logic [7:0] cfg);
    cfr_act_t a;
    a = ACT_HOLD;
    if (cfg[RESP_MSB:RESP_LSB] == RESP_FOLLOW) begin
      a = ACT_FOLLOW;
    end else if (cfg[RESP_MSB:RESP_LSB] == RESP_LATCH &&
                 cfg[RETRY_MSB:RETRY_LSB] == RETRY_LOOP) begin
      a = ACT_RETRY;
    end
    return a;
  endfunction

endpackage

// >>> cfr_stage.sv
// Purpose: Power stage comparator model
// Assumes: Load requests come from the bench
// Notes:   Overcurrent only flows while the output is on
`timescale 1ns/1ps
module cfr_stage (
  // Clock
  input  wire logic       mclk_i,
  // Load and enable
  input  wire logic [1:0] oc_load_i,
  input  wire logic [1:0] uc_load_i,
  input  wire logic [1:0] out_en_i,
  // Comparator pins
  output logic      [1:0] oc_fault_o,
  output logic      [1:0] uc_fault_o
);
  initial {oc_fault_o, uc_fault_o} = 4'h0;
  // Shorted load trips only when powered, so off phases clear it
  always @(negedge mclk_i) begin
    oc_fault_o <= oc_load_i & out_en_i;
    uc_fault_o <= uc_load_i;
  end
endmodule

// >>> cfr_top.sv
// Purpose: Per-output overcurrent / undercurrent fault response controller
// Assumes: Fault, enable and bias inputs are asynchronous pins
// Notes:   Command port carries one byte per access, page selects the copy
//
// Functional notes
// - Response 10: off at once, then retry policy
// - Response 11: off only while fault persists
// - Any overcurrent or undercurrent fault pulls alert line low
// - Any fault sets matching status flag
// - Flags clear only by clear-faults command
// - Retry 000: stay off until cleared
// - Retry 111: restart endlessly until stopped
// - Restart spacing is (delay+1) times 35 ms
// - Undercurrent cfg resets to 80h
// - Undercurrent event sets undercurrent status flag
// - Undercurrent cfg kept per output page
// - Undercurrent cfg moves as one byte
// - Overcurrent event sets overcurrent status flag
// - Overcurrent cfg resets to 80h
`timescale 1ns/1ps

module cfr_top #(
  parameter int unsigned UNIT_CYCLES = cfr_pkg::UNIT_CYC
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // Command port
  input  wire logic       cmd_stb_i,
  input  wire logic       cmd_wr_i,
  input  wire logic [7:0] cmd_code_i,
  input  wire logic       cmd_page_i,
  input  wire logic [7:0] cmd_data_i,
  input  wire logic       clear_faults_i,
  // Power stage pins
  input  wire logic [1:0] oc_fault_i,
  input  wire logic [1:0] uc_fault_i,
  input  wire logic [1:0] on_cmd_i,
  input  wire logic [1:0] other_fault_i,
  input  wire logic       bias_ok_i,
  // Read answer
  output logic      [7:0] rd_data_o,
  output logic            rd_ack_o,
  // Output control and status
  output logic      [1:0] out_en_o,
  output logic      [1:0] oc_flag_o,
  output logic      [1:0] uc_flag_o,
  output logic            host_alert_n_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [8:0] meta_r;
  logic [8:0] sync_r;
  logic [1:0] oc_s;
  logic [1:0] uc_s;
  logic [1:0] on_s;
  logic [1:0] oth_s;
  logic       bias_s;

  // Two stages, nothing reads the first
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {bias_ok_i, other_fault_i, on_cmd_i, uc_fault_i, oc_fault_i};
      sync_r <= meta_r;
    end
  end

  assign oc_s   = sync_r[1:0];
  assign uc_s   = sync_r[3:2];
  assign on_s   = sync_r[5:4];
  assign oth_s  = sync_r[7:6];
  assign bias_s = sync_r[8];

  // ----------------------------------------
  // Configuration bytes, one pair per page
  // ----------------------------------------
  logic [7:0] oc_cfg_r [cfr_pkg::NPAGE];
  logic [7:0] uc_cfg_r [cfr_pkg::NPAGE];
  wire        wr_oc = cmd_stb_i & cmd_wr_i & (cmd_code_i == cfr_pkg::CMD_OC_CFG);
  wire        wr_uc = cmd_stb_i & cmd_wr_i & (cmd_code_i == cfr_pkg::CMD_UC_CFG);
  wire        rd_go = cmd_stb_i & ~cmd_wr_i;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int p = 0; p < cfr_pkg::NPAGE; p++) begin
        oc_cfg_r[p] <= cfr_pkg::RST_OC_CFG;
        uc_cfg_r[p] <= cfr_pkg::RST_UC_CFG;
      end
    end else begin
      if (wr_oc) begin
        oc_cfg_r[cmd_page_i] <= cmd_data_i;
      end
      if (wr_uc) begin
        uc_cfg_r[cmd_page_i] <= cmd_data_i;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] rd_sel;
  logic [7:0] rd_data_r;
  logic       rd_ack_r;

  assign rd_sel = (cmd_code_i == cfr_pkg::CMD_OC_CFG) ? oc_cfg_r[cmd_page_i] :
                  (cmd_code_i == cfr_pkg::CMD_UC_CFG) ? uc_cfg_r[cmd_page_i] :
                  cfr_pkg::RD_NONE;

  // Answer one cycle after the strobe
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_r <= cfr_pkg::RD_NONE;
      rd_ack_r  <= 1'b0;
    end else begin
      rd_ack_r  <= rd_go;
      if (rd_go) begin
        rd_data_r <= rd_sel;
      end
    end
  end

  assign rd_data_o = rd_data_r;
  assign rd_ack_o  = rd_ack_r;

  // ----------------------------------------
  // Status flags and alert
  // ----------------------------------------
  logic [1:0] oc_flag_r;
  logic [1:0] uc_flag_r;
  logic [1:0] oc_flag_nxt;
  logic [1:0] uc_flag_nxt;
  logic       alert_n_r;

  assign oc_flag_nxt = oc_s | (oc_flag_r & {2{~clear_faults_i}});
  assign uc_flag_nxt = uc_s | (uc_flag_r & {2{~clear_faults_i}});

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      oc_flag_r <= '0;
      uc_flag_r <= '0;
      alert_n_r <= 1'b1;
    end else begin
      oc_flag_r <= oc_flag_nxt;
      uc_flag_r <= uc_flag_nxt;
      alert_n_r <= ~(|oc_flag_nxt | |uc_flag_nxt);
    end
  end

  assign oc_flag_o      = oc_flag_r;
  assign uc_flag_o      = uc_flag_r;
  assign host_alert_n_o = alert_n_r;

  // ----------------------------------------
  // Per-page response machines
  // ----------------------------------------
  logic [1:0] out_en_r;

  assign out_en_o = out_en_r;

  for (genvar g = 0; g < cfr_pkg::NPAGE; g++) begin : g_page
    cfr_pkg::cfr_state_t          st_r;
    cfr_pkg::cfr_state_t          st_nxt;
    cfr_pkg::cfr_act_t            act;
    logic [cfr_pkg::PRE_W-1:0]    pre_r;
    logic [2:0]                   unit_r;
    logic [2:0]                   dly_r;
    logic [2:0]                   dly_nxt;
    logic                         kind_r;
    logic                         kind_nxt;
    logic                         arm_r;
    logic                         arm_nxt;
    logic                         tmr_rst;
    logic                         hit;
    logic                         run_ok;
    logic                         gone;
    logic                         tick;
    logic                         expire;
    logic [7:0]                   cfg_hit;

    // Fault sampled only while the output is really on
    assign run_ok  = on_s[g] & bias_s & ~oth_s[g];
    assign hit     = (oc_s[g] | uc_s[g]) & run_ok;
    // Overcurrent takes priority when both trip together
    assign cfg_hit = oc_s[g] ? oc_cfg_r[g] : uc_cfg_r[g];
    // reserved codes decode as latched shutdown
    assign act     = cfr_pkg::cfr_decode(cfg_hit);
    assign gone    = kind_r ? ~oc_s[g] : ~uc_s[g];
    assign tick    = (pre_r == cfr_pkg::PRE_W'(UNIT_CYCLES - 1));
    assign expire  = arm_r & tick & (unit_r == dly_r);

    // Next state
    always_comb begin
      st_nxt   = st_r;
      arm_nxt  = arm_r;
      tmr_rst  = 1'b0;
      dly_nxt  = dly_r;
      kind_nxt = kind_r;
      unique case (st_r)
        cfr_pkg::ST_RUN: begin
          if (hit) begin
            kind_nxt = oc_s[g];
            unique case (act)
              cfr_pkg::ACT_HOLD: begin
                st_nxt  = cfr_pkg::ST_HOLD;
                arm_nxt = 1'b0;
              end
              cfr_pkg::ACT_RETRY: begin
                st_nxt  = cfr_pkg::ST_RETRY;
                dly_nxt = cfg_hit[cfr_pkg::DLY_MSB:cfr_pkg::DLY_LSB];
                if (!arm_r) begin
                  arm_nxt = 1'b1;
                  tmr_rst = 1'b1;
                end
              end
              default: begin
                st_nxt  = cfr_pkg::ST_FOLLOW;
                arm_nxt = 1'b0;
              end
            endcase
          end else if (expire || !run_ok) begin
            // A full quiet period ends the retry series
            arm_nxt = 1'b0;
          end
        end
        cfr_pkg::ST_HOLD: begin
          if (clear_faults_i) begin
            st_nxt = cfr_pkg::ST_RUN;
          end
        end
        cfr_pkg::ST_FOLLOW: begin
          if (gone) begin
            st_nxt = cfr_pkg::ST_RUN;
          end
        end
        cfr_pkg::ST_RETRY: begin
          if (!run_ok) begin
            st_nxt  = cfr_pkg::ST_RUN;
            arm_nxt = 1'b0;
          end else if (expire) begin
            st_nxt  = cfr_pkg::ST_RUN;
            tmr_rst = 1'b1;
          end
        end
        default: begin
          st_nxt  = cfr_pkg::ST_HOLD;
          arm_nxt = 1'b0;
        end
      endcase
    end

    // State and capture registers
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        st_r   <= cfr_pkg::ST_RUN;
        arm_r  <= 1'b0;
        dly_r  <= 3'h0;
        kind_r <= 1'b0;
      end else begin
        st_r   <= st_nxt;
        arm_r  <= arm_nxt;
        dly_r  <= dly_nxt;
        kind_r <= kind_nxt;
      end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        pre_r  <= '0;
        unit_r <= 3'h0;
      end else if (tmr_rst || !arm_r) begin
        pre_r  <= '0;
        unit_r <= 3'h0;
      end else if (tick) begin
        pre_r  <= '0;
        unit_r <= unit_r + 3'h1;
      end else begin
        pre_r  <= pre_r + cfr_pkg::PRE_W'(1);
      end
    end

    // enable gated the same cycle the fault is seen
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        out_en_r[g] <= 1'b0;
      end else begin
        out_en_r[g] <= (st_nxt == cfr_pkg::ST_RUN) & run_ok & ~hit;
      end
    end
  end

endmodule

// >>> current_fault_response_tb.sv
// Purpose: Self-checking bench for the fault response block
// Assumes: Short retry unit of 4 cycles
// Notes:   Inputs change on falling edges only
`timescale 1ns/1ps
module current_fault_response_tb;
  logic       mclk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       cmd_stb_i = 1'b0;
  logic       cmd_wr_i = 1'b0;
  logic [7:0] cmd_code_i = 8'h00;
  logic       cmd_page_i = 1'b0;
  logic [7:0] cmd_data_i = 8'h00;
  logic       clear_faults_i = 1'b0;
  logic [1:0] oc_load = 2'h0;
  logic [1:0] uc_load = 2'h0;
  logic [1:0] on_cmd_i = 2'h3;
  logic [1:0] other_fault_i = 2'h0;
  logic       bias_ok_i = 1'b1;
  logic [1:0] oc_fault_i, uc_fault_i, out_en_o, oc_flag_o, uc_flag_o;
  logic [7:0] rd_data_o;
  logic       rd_ack_o, host_alert_n_o;
  int         n_mismatch = 0, check_count = 0, cyc = 0, n = 0;
  // Clock, and a hang limit well past the run length
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  cfr_top #(.UNIT_CYCLES(4)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_stb_i(cmd_stb_i), .cmd_wr_i(cmd_wr_i),
    .cmd_code_i(cmd_code_i), .cmd_page_i(cmd_page_i), .cmd_data_i(cmd_data_i), .clear_faults_i(clear_faults_i),
    .oc_fault_i(oc_fault_i), .uc_fault_i(uc_fault_i), .on_cmd_i(on_cmd_i), .other_fault_i(other_fault_i),
    .bias_ok_i(bias_ok_i),
    .rd_data_o(rd_data_o), .rd_ack_o(rd_ack_o), .out_en_o(out_en_o), .oc_flag_o(oc_flag_o),
    .uc_flag_o(uc_flag_o), .host_alert_n_o(host_alert_n_o));
  cfr_stage stage (.mclk_i(mclk_i), .oc_load_i(oc_load), .uc_load_i(uc_load), .out_en_i(out_en_o),
    .oc_fault_o(oc_fault_i), .uc_fault_o(uc_fault_i));
  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic w, input logic [7:0] c, input logic p, input logic [7:0] d);
    {cmd_stb_i, cmd_wr_i, cmd_code_i, cmd_page_i, cmd_data_i} = {1'b1, w, c, p, d};
    @(negedge mclk_i);
    cmd_stb_i = 1'b0;
    // Idle edge keeps back-to-back strobes apart
    @(negedge mclk_i);
  endtask
  task automatic rd_chk(input logic [7:0] c, input logic p, input logic [7:0] e);
    {cmd_stb_i, cmd_wr_i, cmd_code_i, cmd_page_i} = {1'b1, 1'b0, c, p};
    @(negedge mclk_i);
    chk({7'h00, rd_ack_o}, 8'h01);
    chk(rd_data_o, e);
    cmd_stb_i = 1'b0;
    @(negedge mclk_i);
    chk({7'h00, rd_ack_o}, 8'h00);
  endtask
  task automatic wait_en(input int p, input logic v);
    n = 0;
    while (out_en_o[p] !== v && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    chk({7'h00, out_en_o[p]}, {7'h00, v});
  endtask
  task automatic clr();
    clear_faults_i = 1'b1;
    @(negedge mclk_i);
    clear_faults_i = 1'b0;
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_regs();
    rd_chk(8'he5, 1'b0, 8'h80);
    rd_chk(8'he6, 1'b1, 8'h80);
    cmd(1'b1, 8'he6, 1'b1, 8'hc0);
    rd_chk(8'he6, 1'b1, 8'hc0);
    rd_chk(8'he6, 1'b0, 8'h80);
  endtask
  task automatic t_latch(input logic [7:0] cfg);
    cmd(1'b1, 8'he5, 1'b0, cfg);
    rd_chk(8'he5, 1'b0, cfg);
    oc_load = 2'h1;
    wait_en(0, 1'b0);
    chk({6'h00, oc_flag_o}, 8'h01);
    chk({7'h00, host_alert_n_o}, 8'h00);
    oc_load = 2'h0;
    repeat (12) @(negedge mclk_i);
    chk({7'h00, out_en_o[0]}, 8'h00);
    chk({6'h00, oc_flag_o}, 8'h01);
    clr();
    wait_en(0, 1'b1);
    chk({7'h00, host_alert_n_o}, 8'h01);
  endtask
  task automatic t_follow();
    uc_load = 2'h2;
    wait_en(1, 1'b0);
    chk({6'h00, uc_flag_o}, 8'h02);
    uc_load = 2'h0;
    wait_en(1, 1'b1);
    chk({6'h00, uc_flag_o}, 8'h02);
    clr();
    @(negedge mclk_i);
    chk({6'h00, uc_flag_o}, 8'h00);
  endtask
  task automatic t_retry();
    cmd(1'b1, 8'he5, 1'b0, 8'hb9);
    oc_load = 2'h1;
    wait_en(0, 1'b0);
    wait_en(0, 1'b1);
    n = 0;
    while (out_en_o[0] === 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    while (out_en_o[0] !== 1'b1 && n < 40) begin
      @(negedge mclk_i);
      n++;
    end
    chk(n[7:0], 8'h08);
    on_cmd_i = 2'h2;
    repeat (30) @(negedge mclk_i);
    chk({7'h00, out_en_o[0]}, 8'h00);
    on_cmd_i = 2'h3;
    wait_en(0, 1'b1);
    // Bias loss ends the series on page 0 and drops both outputs
    bias_ok_i = 1'b0;
    repeat (30) @(negedge mclk_i);
    chk({6'h00, out_en_o}, 8'h00);
    bias_ok_i = 1'b1;
    wait_en(0, 1'b1);
    // Another shutdown fault ends it too
    other_fault_i = 2'h1;
    repeat (30) @(negedge mclk_i);
    chk({7'h00, out_en_o[0]}, 8'h00);
    oc_load = 2'h0;
    other_fault_i = 2'h0;
    cmd(1'b1, 8'he5, 1'b0, 8'h80);
    clr();
    wait_en(0, 1'b1);
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_i = 1'b0;
    wait_en(0, 1'b1);
    t_regs();
    rd_chk(8'he7, 1'b0, 8'h00);
    t_latch(8'h80);
    t_follow();
    t_retry();
    t_latch(8'h40);
    t_latch(8'h91);
    stop_test();
  end
endmodule
